// ===== rtl/insn_core.sv
`timescale 1ns/1ps
module insn_core (
  input  wire logic        pclk,          // Clock, 100 MHz
  input  wire logic        presetn,       // Async reset, active low
  input  wire logic        ce,            // Clock enable, freezes state
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB enable
  input  wire logic        pwrite,        // APB direction
  input  wire logic [7:0]  paddr,         // APB byte address
  input  wire logic [31:0] pwdata,        // APB write data
  output logic      [31:0] prdata,        // APB read data
  output logic             pready,        // APB ready
  output logic             pslverr,       // APB error, unmapped
  input  wire logic [7:0]  port_pins,     // Port pin levels
  output logic      [7:0]  port_latch,    // Port output latch
  output logic             prescaler_clr, // Timer prescaler clear pulse
  output logic             standby_req,   // Standby entry pulse
  output logic             watchdog_clr,  // Watchdog clear pulse
  input  wire logic        prog_clk,      // Serial programming clock
  input  wire logic        prog_data      // Serial programming data
);
  import core14_pkg::*;

  typedef struct packed {
    exec_state_e          st;
    logic [1:0]           dly;
    logic [INSN_W-1:0]    insn;
    logic [7:0]           acc;
    logic                 carry;
    logic                 dcarry;
    logic                 zero;
    logic                 pd;
    logic                 to;
    logic [PC_W-1:0]      pc;
    logic [PC_W-1:0]      ret;
    logic                 two;
    logic [3:0]           ctrl;
    logic [3:0][13:0]     id;
    logic [7:0]           fval;
    logic [7:0]           port_lat;
    logic                 sleep_p;
    logic                 wdt_p;
    logic                 pre_p;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 pclk_prev;
    logic [13:0]          shreg;
    logic [3:0]           shcnt;
    logic [1:0]           idptr;
  } core_s;

  localparam core_s CORE_RST = '{st: S_IDLE, ctrl: CTRL_RST, pd: 1'b1,
                                 to: 1'b1, default: '0};

  core_s st_ff;
  core_s nxt_st;
  rf_if  rf ();

  file_mem u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .rf      (rf.mem)
  );

  // Add with carry in; returns {digit carry, carry, sum}
  function automatic logic [9:0] addc(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic       cin);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    return {h[4], s};
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic [6:0]  f;
    logic        d;
    logic [2:0]  b;
    logic [7:0]  k;
    logic [7:0]  res;
    logic [9:0]  sum;
    logic        wf;
    logic        ww;
    logic        dst;
    logic        skip;
    logic        jmp;
    logic        rdok;
    logic [13:0] sh;
    logic [1:0]  idx;
    f    = st_ff.insn[6:0];
    d    = st_ff.insn[7];
    b    = st_ff.insn[9:7];
    k    = st_ff.insn[7:0];
    res  = 8'h00;
    sum  = 10'h000;
    wf   = 1'b0;
    ww   = 1'b0;
    dst  = 1'b0;
    skip = 1'b0;
    jmp  = 1'b0;
    rdok = st_ff.ctrl[CTRL_PROG] & st_ff.ctrl[CTRL_CP0]
         & st_ff.ctrl[CTRL_CP1];
    sh   = 14'h0000;
    idx  = paddr[3:2];
    nxt_st         = st_ff;
    nxt_st.sleep_p = 1'b0;
    nxt_st.wdt_p   = 1'b0;
    nxt_st.pre_p   = 1'b0;
    rf.we    = 1'b0;
    rf.waddr = f;
    rf.wdata = 8'h00;
    rf.raddr = f;

    // -------------------------------------------------------------
    // APB slave: ready one cycle into access, writes land on the edge that samples it
    // -------------------------------------------------------------
    nxt_st.pready  = psel & penable & ~st_ff.pready;
    nxt_st.pslverr = 1'b0;
    if (psel && penable && !st_ff.pready) begin
      nxt_st.prdata = 32'h0000_0000;
      if (paddr == ADDR_CTRL) begin
        nxt_st.prdata = {28'h0, st_ff.ctrl};
      end else if (paddr == ADDR_INSN) begin
        nxt_st.prdata = {18'h0, st_ff.insn};
      end else if (paddr == ADDR_ACC) begin
        nxt_st.prdata = {24'h0, st_ff.acc};
      end else if (paddr == ADDR_STATUS) begin
        nxt_st.prdata = {26'h0, st_ff.st != S_IDLE, st_ff.to,
                         st_ff.pd, st_ff.zero, st_ff.dcarry, st_ff.carry};
      end else if (paddr == ADDR_PC) begin
        nxt_st.prdata = {19'h0, st_ff.pc};
      end else if (paddr == ADDR_VERIFY) begin
        if (rdok) begin
          nxt_st.prdata = {18'h0, st_ff.insn};
        end
      end else if (paddr >= ADDR_ID0 && paddr <= ADDR_ID3 &&
                   paddr[1:0] == 2'b00) begin
        if (st_ff.ctrl[CTRL_PROG]) begin
          nxt_st.prdata = {18'h0, st_ff.id[idx]};
        end
      end else begin
        nxt_st.pslverr = 1'b1;
      end
    end else if (!(psel && penable)) begin
      nxt_st.pslverr = 1'b0;
    end

    // Writes take effect on the edge the master samples ready
    if (psel && penable && st_ff.pready && pwrite) begin
      if (paddr == ADDR_CTRL) begin
        nxt_st.ctrl = pwdata[3:0];
      end else if (paddr == ADDR_INSN) begin
        // A word sent while busy is dropped; poll busy first
        if (st_ff.st == S_IDLE) begin
          nxt_st.insn = pwdata[INSN_W-1:0];
          nxt_st.st   = S_Q1;
        end
      end else if (paddr >= ADDR_ID0 && paddr <= ADDR_ID3 &&
                   paddr[1:0] == 2'b00) begin
        if (st_ff.ctrl[CTRL_PROG]) begin
          nxt_st.id[idx] = pwdata[13:0];
        end
      end
    end

    // -------------------------------------------------------------
    // Execution, four clocks per instruction cycle
    // -------------------------------------------------------------
    case (st_ff.st)
      S_IDLE: begin
        nxt_st.two = 1'b0;
      end
      S_Q1: begin
        nxt_st.st = S_Q2;
      end
      S_Q2: begin
        // Port reads see the pins so input bits write back their level
        nxt_st.fval = (f == FILE_PORT) ? port_pins : rf.rdata;
        nxt_st.st   = S_Q3;
      end
      S_Q3: begin
        case (st_ff.insn[13:12])
          GRP_BYTE: begin
            case (st_ff.insn[11:8])
              OP_STORE_ACC_TO_FILE: begin
                if (d) begin
                  res = st_ff.acc;
                  wf  = 1'b1;
                end else if (st_ff.insn == W_RETURN ||
                             st_ff.insn == W_INTERRUPT_RETURN) begin
                  jmp = 1'b1;
                  nxt_st.pc = st_ff.ret;
                end else if (st_ff.insn == W_STANDBY) begin
                  nxt_st.pd      = 1'b0;
                  nxt_st.to      = 1'b1;
                  nxt_st.sleep_p = 1'b1;
                end else if (st_ff.insn == W_WATCHDOG_CLEAR) begin
                  nxt_st.pd    = 1'b1;
                  nxt_st.to    = 1'b1;
                  nxt_st.wdt_p = 1'b1;
                end
                // Anything else here is a no-op
              end
              OP_CLEAR: begin
                res = 8'h00;
                dst = 1'b1;
                nxt_st.zero = 1'b1;
              end
              OP_ADD_ACC_TO_FILE, OP_SUB_ACC_FROM_FILE: begin
                sum = (st_ff.insn[11:8] == OP_ADD_ACC_TO_FILE) ?
                      addc(st_ff.fval, st_ff.acc, 1'b0) :
                      addc(st_ff.fval, ~st_ff.acc, 1'b1);
                res = sum[7:0];
                dst = 1'b1;
                nxt_st.carry  = sum[8];
                nxt_st.dcarry = sum[9];
                nxt_st.zero   = (sum[7:0] == 8'h00);
              end
              OP_INCREMENT_FILE, OP_DECREMENT_FILE, OP_MOVE_FILE,
              OP_AND_ACC_WITH_FILE, OP_OR_ACC_WITH_FILE,
              OP_XOR_ACC_WITH_FILE, OP_COMPLEMENT_FILE: begin
                case (st_ff.insn[11:8])
                  OP_INCREMENT_FILE:    res = st_ff.fval + 8'h01;
                  OP_DECREMENT_FILE:    res = st_ff.fval - 8'h01;
                  OP_MOVE_FILE:         res = st_ff.fval;
                  OP_AND_ACC_WITH_FILE: res = st_ff.fval & st_ff.acc;
                  OP_OR_ACC_WITH_FILE:  res = st_ff.fval | st_ff.acc;
                  OP_XOR_ACC_WITH_FILE: res = st_ff.fval ^ st_ff.acc;
                  default:              res = ~st_ff.fval;
                endcase
                dst = 1'b1;
                nxt_st.zero = (res == 8'h00);
              end
              OP_ROTATE_LEFT_CARRY: begin
                {nxt_st.carry, res} = {st_ff.fval, st_ff.carry};
                dst = 1'b1;
              end
              OP_ROTATE_RIGHT_CARRY: begin
                {res, nxt_st.carry} = {st_ff.carry, st_ff.fval};
                dst = 1'b1;
              end
              OP_SWAP_FILE_NIBBLES: begin
                res = {st_ff.fval[3:0], st_ff.fval[7:4]};
                dst = 1'b1;
              end
              default: begin
                // Skip forms leave every flag alone
                res  = (st_ff.insn[11:8] == OP_DECREMENT_SKIP) ?
                       st_ff.fval - 8'h01 : st_ff.fval + 8'h01;
                dst  = 1'b1;
                skip = (res == 8'h00);
              end
            endcase
            if (dst) begin
              wf = d;
              ww = ~d;
            end
          end
          GRP_BIT: begin
            case (st_ff.insn[11:10])
              OP_BIT_CLEAR: begin
                res = st_ff.fval & ~(8'h01 << b);
                wf  = 1'b1;
              end
              OP_BIT_SET: begin
                res = st_ff.fval | (8'h01 << b);
                wf  = 1'b1;
              end
              OP_BIT_TEST_SKIP_CLR: skip = ~st_ff.fval[b];
              default:              skip = st_ff.fval[b];
            endcase
          end
          GRP_JUMP: begin
            // Bit 11 splits subroutine call from plain jump
            if (!st_ff.insn[11]) begin
              nxt_st.ret = st_ff.pc + 13'h0001;
            end
            nxt_st.pc = {2'b00, st_ff.insn[10:0]};
            jmp = 1'b1;
          end
          default: begin
            // Don't-care bits fall out of the casez masks
            casez (st_ff.insn[11:8])
              4'b00??: ww = 1'b1;
              4'b01??: begin
                ww  = 1'b1;
                jmp = 1'b1;
                nxt_st.pc = st_ff.ret;
              end
              4'b1000, 4'b1001, 4'b1010: begin
                res = (st_ff.insn[9:8] == 2'b00) ? (k | st_ff.acc) :
                      (st_ff.insn[9:8] == 2'b01) ? (k & st_ff.acc) :
                                                   (k ^ st_ff.acc);
                nxt_st.acc  = res;
                nxt_st.zero = (res == 8'h00);
              end
              4'b11??: begin
                sum = st_ff.insn[9] ? addc(k, st_ff.acc, 1'b0) :
                                      addc(k, ~st_ff.acc, 1'b1);
                nxt_st.acc    = sum[7:0];
                nxt_st.carry  = sum[8];
                nxt_st.dcarry = sum[9];
                nxt_st.zero   = (sum[7:0] == 8'h00);
              end
              default: ;
            endcase
            if (ww) begin
              res = k;
            end
          end
        endcase
        if (ww) begin
          nxt_st.acc = res;
        end
        rf.we    = wf;
        rf.wdata = res;
        if (wf && f == FILE_TIMER && st_ff.ctrl[CTRL_PSA]) begin
          nxt_st.pre_p = 1'b1;
        end
        if (wf && f == FILE_PORT) begin
          nxt_st.port_lat = res;
        end
        if (!jmp) begin
          nxt_st.pc = st_ff.pc + (skip ? 13'h0002 : 13'h0001);
        end
        nxt_st.two = jmp | skip;
        nxt_st.st  = S_Q4;
      end
      S_Q4: begin
        nxt_st.dly = DUMMY_LAST;
        nxt_st.st  = st_ff.two ? S_DUMMY : S_IDLE;
      end
      S_DUMMY: begin
        // Second cycle is a full no-op cycle
        if (st_ff.dly == 2'b00) begin
          nxt_st.st = S_IDLE;
        end else begin
          nxt_st.dly = st_ff.dly - 2'b01;
        end
      end
      default: nxt_st.st = S_IDLE;
    endcase

    // -------------------------------------------------------------
    // Two-wire serial loader for ID words, LSB first
    // -------------------------------------------------------------
    nxt_st.pclk_prev = prog_clk;
    if (!st_ff.ctrl[CTRL_PROG]) begin
      nxt_st.shcnt = 4'h0;
    end else if (prog_clk && !st_ff.pclk_prev) begin
      sh = {prog_data, st_ff.shreg[13:1]};
      nxt_st.shreg = sh;
      if (st_ff.shcnt == 4'(INSN_W - 1)) begin
        nxt_st.shcnt = 4'h0;
        nxt_st.id[st_ff.idptr] = sh;
        nxt_st.idptr = st_ff.idptr + 2'b01;
      end else begin
        nxt_st.shcnt = st_ff.shcnt + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= CORE_RST;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign prdata        = st_ff.prdata;
  assign pready        = st_ff.pready;
  assign pslverr       = st_ff.pslverr;
  assign port_latch    = st_ff.port_lat;
  assign prescaler_clr = st_ff.pre_p;
  assign standby_req   = st_ff.sleep_p;
  assign watchdog_clr  = st_ff.wdt_p;
endmodule

// ===== rtl/core14_pkg.sv
package core14_pkg;

  // ---------------------------------------------------------------
  // Widths and timing
  // ---------------------------------------------------------------
  localparam int INSN_W      = 14;
  localparam int FADDR_W     = 7;
  localparam int PC_W        = 13;
  localparam int Q_PER_CYCLE = 4;  // Oscillator periods per cycle
  localparam logic [1:0] DUMMY_LAST = 2'(Q_PER_CYCLE - 1);
  localparam int ID_COUNT    = 4;
  localparam logic [15:0] ID_BASE = 16'h2000;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_INSN   = 8'h04;
  localparam logic [7:0] ADDR_ACC    = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_PC     = 8'h10;
  localparam logic [7:0] ADDR_VERIFY = 8'h14;
  localparam logic [7:0] ADDR_ID0    = 8'h20;
  localparam logic [7:0] ADDR_ID3    = 8'h2c;

  // Control fields
  localparam int CTRL_PROG = 0;
  localparam int CTRL_CP0  = 1;
  localparam int CTRL_CP1  = 2;
  localparam int CTRL_PSA  = 3;
  localparam logic [3:0] CTRL_RST = 4'h6;  // Protection unprogrammed

  // Status fields
  localparam int ST_CARRY = 0;
  localparam int ST_DC    = 1;
  localparam int ST_ZERO  = 2;
  localparam int ST_PD    = 3;
  localparam int ST_TO    = 4;
  localparam int ST_BUSY  = 5;

  // Special file addresses
  localparam logic [6:0] FILE_TIMER = 7'h01;
  localparam logic [6:0] FILE_PORT  = 7'h06;

  // ---------------------------------------------------------------
  // Byte-oriented operation codes
  // ---------------------------------------------------------------
  localparam logic [3:0] OP_STORE_ACC_TO_FILE  = 4'h0;
  localparam logic [3:0] OP_CLEAR              = 4'h1;
  localparam logic [3:0] OP_SUB_ACC_FROM_FILE  = 4'h2;
  localparam logic [3:0] OP_DECREMENT_FILE     = 4'h3;
  localparam logic [3:0] OP_OR_ACC_WITH_FILE   = 4'h4;
  localparam logic [3:0] OP_AND_ACC_WITH_FILE  = 4'h5;
  localparam logic [3:0] OP_XOR_ACC_WITH_FILE  = 4'h6;
  localparam logic [3:0] OP_ADD_ACC_TO_FILE    = 4'h7;
  localparam logic [3:0] OP_MOVE_FILE          = 4'h8;
  localparam logic [3:0] OP_COMPLEMENT_FILE    = 4'h9;
  localparam logic [3:0] OP_INCREMENT_FILE     = 4'ha;
  localparam logic [3:0] OP_DECREMENT_SKIP     = 4'hb;
  localparam logic [3:0] OP_ROTATE_RIGHT_CARRY = 4'hc;
  localparam logic [3:0] OP_ROTATE_LEFT_CARRY  = 4'hd;
  localparam logic [3:0] OP_SWAP_FILE_NIBBLES  = 4'he;
  localparam logic [3:0] OP_INCREMENT_SKIP     = 4'hf;

  // Bit-oriented operation codes
  localparam logic [1:0] OP_BIT_CLEAR          = 2'h0;
  localparam logic [1:0] OP_BIT_SET            = 2'h1;
  localparam logic [1:0] OP_BIT_TEST_SKIP_CLR  = 2'h2;
  localparam logic [1:0] OP_BIT_TEST_SKIP_SET  = 2'h3;

  // Group prefixes
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT  = 2'h1;
  localparam logic [1:0] GRP_JUMP = 2'h2;
  localparam logic [1:0] GRP_LIT  = 2'h3;

  // Fixed control words
  localparam logic [13:0] W_RETURN           = 14'h0008;
  localparam logic [13:0] W_INTERRUPT_RETURN = 14'h0009;
  localparam logic [13:0] W_STANDBY          = 14'h0063;
  localparam logic [13:0] W_WATCHDOG_CLEAR   = 14'h0064;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_Q1    = 3'b001,
    S_Q2    = 3'b010,
    S_Q3    = 3'b011,
    S_Q4    = 3'b100,
    S_DUMMY = 3'b101
  } exec_state_e;

endpackage

// ===== rtl/rf_if.sv
`timescale 1ns/1ps
// Register file access between core and storage
interface rf_if;
  logic       we;
  logic [6:0] waddr;
  logic [7:0] wdata;
  logic [6:0] raddr;
  logic [7:0] rdata;
  modport core (output we, output waddr, output wdata, output raddr,
                input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr,
                output rdata);
endinterface

// ===== rtl/file_mem.sv
`timescale 1ns/1ps
module file_mem (
  input  wire logic pclk,    // Clock
  input  wire logic presetn, // Async reset, active low
  input  wire logic ce,      // Clock enable
  rf_if.mem         rf       // Core side
);
  import core14_pkg::*;

  logic [7:0] mem_q [2**FADDR_W];
  logic [7:0] rdata_ff;

  // ---------------------------------------------------------------
  // Storage, read data registered
  // ---------------------------------------------------------------
  // Array left unreset; software must initialise files it reads
  always_ff @(posedge pclk) begin
    if (ce && rf.we) begin
      mem_q[rf.waddr] <= rf.wdata;
    end
  end

  // Read lands one edge after the address is presented
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 8'h00;
    end else if (ce) begin
      rdata_ff <= mem_q[rf.raddr];
    end
  end

  assign rf.rdata = rdata_ff;
endmodule

// ===== verification/core14_monitor.sv
`timescale 1ns/1ps
// Bus and execution timing watcher
module core14_monitor
  import core14_pkg::*;
(
  input wire logic        pclk,          // Clock
  input wire logic        presetn,       // Reset
  input wire logic        psel,          // Select
  input wire logic        penable,       // Enable
  input wire logic        pwrite,        // Direction
  input wire logic [7:0]  paddr,         // Address
  input wire logic [31:0] pwdata,        // Write data
  input wire logic [31:0] prdata,        // Read data
  input wire logic        pready,        // Ready
  input wire logic        pslverr,       // Error
  input wire logic [7:0]  port_latch,    // Port latch
  input wire logic        prescaler_clr, // Prescaler clear
  input wire logic        standby_req,   // Standby
  input wire logic        watchdog_clr   // Watchdog
);
  // Accepted word; its effects land four edges later
  wire take = psel && penable && pready && pwrite && paddr == ADDR_INSN;
  wire sb_w = take && pwdata[13:0] == W_STANDBY;
  wire wd_w = take && pwdata[13:0] == W_WATCHDOG_CLEAR;
  wire tm_w = take && pwdata[6:0] == FILE_TIMER;
  wire pt_w = take && pwdata[6:0] == FILE_PORT;
  wire mapped = paddr[1:0] == 2'h0 && (paddr <= ADDR_VERIFY ||
                (paddr >= ADDR_ID0 && paddr <= ADDR_ID3));
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY_WAIT: assert property (
    psel && penable && !pready |=> pready)
    else $error("late ready");
  AST_READY_PULSE: assert property (
    pready |=> !pready)
    else $error("ready held");
  AST_ERR_MAP: assert property (
    pready |-> pslverr == !mapped)
    else $error("error flag wrong");
  AST_ERR_ZERO: assert property (
    pready && pslverr && !pwrite |-> prdata == 0)
    else $error("refused read gave data");
  AST_STANDBY: assert property (
    standby_req |-> $past(sb_w, 4))
    else $error("stray standby");
  AST_WATCHDOG: assert property (
    watchdog_clr |-> $past(wd_w, 4))
    else $error("stray watchdog clear");
  AST_TIMER: assert property (
    prescaler_clr |-> $past(tm_w, 4))
    else $error("stray prescaler clear");
  AST_PORT: assert property (
    $changed(port_latch) |-> $past(pt_w, 4))
    else $error("stray port write");
  AST_PULSE: assert property (
    standby_req |-> !watchdog_clr ##1 !standby_req)
    else $error("standby pulse wrong");
  cover property (standby_req);
  cover property (prescaler_clr);
  cover property (pready && pslverr);
endmodule

bind insn_core core14_monitor u_mon (.*);

// ===== verification/prog_model.sv
`timescale 1ns/1ps
// Serial programmer, one word per request, low bit first
module prog_model (
  input  wire logic        pclk,      // Clock
  input  wire logic        go,        // Start frame
  input  wire logic [13:0] word,      // Word to send
  output logic             prog_clk,  // Serial clock
  output logic             prog_data, // Serial data
  output logic             busy       // Frame running
);
  // Clock idles low; data toggles when idle so stale bits never pass
  initial begin
    {prog_clk, prog_data, busy} = 3'b0;
    forever begin
      @(posedge pclk);
      if (go) begin
        busy <= 1'b1;
        for (int i = 0; i < 14; i++) begin
          prog_data <= word[i];
          repeat (4) @(posedge pclk);
          prog_clk <= 1'b1;
          repeat (4) @(posedge pclk);
          prog_clk <= 1'b0;
        end
        busy <= 1'b0;
      end else begin
        prog_data <= ~prog_data;
      end
    end
  end
endmodule

// ===== verification/test_risc_14bit_instruction_decoder.sv
`timescale 1ns/1ps
module test_risc_14bit_instruction_decoder;
  import core14_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, go, err, psc_clr;
  logic        pready, pslverr, prog_clk, prog_data, pm_busy;
  logic        sb_req, wd_clr;
  logic [7:0]  paddr, port_pins, port_latch;
  logic [13:0] word;
  logic [31:0] pwdata, prdata, rd;
  int          n_errors, tests_run, cyc, n_psc, n_sb, n_wd, polls;
  // Two-cycle flag (bit 38), word, register read back, expected value
  logic [39:0] steps [24] = '{
    40'h3388_08_0088, 40'h00a0_0c_0018, 40'h0720_08_0010,
    40'h0aa0_08_0010, 40'h0820_08_0089, 40'h390f_08_0009,
    40'h38f0_08_00f9, 40'h3af9_0c_001f, 40'h3e01_0c_0018,
    40'h3c01_0c_001f, 40'h0001_10_000b, 40'h3001_08_0001,
    40'h00a1_10_000d, 40'h4ba1_10_000f, 40'h5821_10_0011,
    40'h1c21_10_0012, 40'h17a1_10_0013, 40'h0fa1_10_0014,
    40'h0821_08_0081, 40'h6923_10_0123, 40'h6045_10_0045,
    40'h4008_10_0124, 40'h0063_0c_0013, 40'h0064_0c_001b
  };
  insn_core dut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .port_pins, .port_latch,
    .prescaler_clr(psc_clr), .standby_req(sb_req), .watchdog_clr(wd_clr),
    .prog_clk, .prog_data);
  prog_model pm (.pclk, .go, .word, .prog_clk, .prog_data, .busy(pm_busy));
  always #5 pclk = ~pclk;
  // Prescaler, standby and watchdog pulse counts and hang guard
  always @(posedge pclk) begin
    cyc++;
    if (psc_clr === 1'b1) n_psc++;
    if (sb_req === 1'b1) n_sb++;
    if (wd_clr === 1'b1) n_wd++;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  // Bus cycle: setup, then access until ready
  task automatic xfer(input logic w, logic [7:0] a, logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Issue one word and wait for idle; 2 polls for 4 clocks, 3 for 8
  task automatic ex(input logic [13:0] i);
    xfer(1'b1, ADDR_INSN, {18'h0, i});
    polls = 0;
    do begin
      xfer(1'b0, ADDR_STATUS, 32'h0);
      polls++;
    end while (rd[ST_BUSY] !== 1'b0);
  endtask
  task automatic give_verdict();
    $display("mismatches %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, go, paddr, pwdata} = '0;
    {port_pins, word} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ADDR_CTRL, 32'h6);
    rdc(ADDR_STATUS, 32'h18);
    foreach (steps[k]) begin
      ex(steps[k][37:24]);
      chk(polls, steps[k][38] ? 32'h3 : 32'h2);
      rdc(steps[k][23:16], {16'h0, steps[k][15:0]});
    end
    chk(n_sb, 32'h1);
    chk(n_wd, 32'h1);
    port_pins <= 8'h0f;
    ex(14'h3033);
    ex(14'h0086);
    chk({24'h0, port_latch}, 32'h33);
    ex(14'h0886);
    chk({24'h0, port_latch}, 32'h0f);
    ex(14'h00ff);
    ex(14'h3000);
    ex(14'h087f);
    rdc(ADDR_ACC, 32'h33);
    xfer(1'b1, ADDR_CTRL, 32'he);
    ex(14'h0181);
    xfer(1'b1, ADDR_CTRL, 32'h6);
    ex(14'h0181);
    chk(n_psc, 32'h1);
    rdc(8'h18, 32'h0);
    chk({31'h0, err}, 32'h1);
    rdc(ADDR_ID0, 32'h0);
    xfer(1'b1, ADDR_CTRL, 32'h1);
    rdc(ADDR_VERIFY, 32'h0);
    xfer(1'b1, ADDR_CTRL, 32'h7);
    rdc(ADDR_VERIFY, 32'h181);
    word <= 14'h2a5;
    go <= 1'b1;
    @(posedge pclk) go <= 1'b0;
    repeat (2) @(posedge pclk);
    while (pm_busy === 1'b1) @(posedge pclk);
    rdc(ADDR_ID0, 32'h2a5);
    give_verdict();
  end
endmodule
